// File: verilog/fcw_pkg.sv
// package for the floating-point control word and rounding block
// assumes a single processor clock and instruction strobes from the sequencer
package fcw_pkg;

	localparam int          FCW_WIDTH      = 16;
	localparam logic [15:0] FCW_INIT_VALUE = 16'h037F;

	// control word field positions
	localparam int FCW_MASK_LSB  = 0;
	localparam int FCW_MASK_MSB  = 5;
	localparam int FCW_PREC_LSB  = 8;
	localparam int FCW_RND_LSB   = 10;
	localparam int FCW_INFC_BIT  = 12;

	// status flag positions inside the six-bit exception group
	localparam int FCW_FLAG_OVF  = 3;
	localparam int FCW_FLAG_INX  = 5;

	// significand: 64 kept bits plus guard, round and sticky
	localparam int SIG_IN_W  = 67;
	localparam int SIG_OUT_W = 64;
	localparam int EXP_W     = 15;

	// shift of the last kept bit inside the 67-bit input
	localparam logic [5:0] SHIFT_EXT = 6'h03;
	localparam logic [5:0] SHIFT_DBL = 6'h0E;
	localparam logic [5:0] SHIFT_SGL = 6'h2B;

	localparam logic [14:0] EXP_INF     = 15'h7FFF;
	localparam logic [14:0] EXP_MAX_FIN = 15'h7FFE;

	typedef enum logic [1:0] {
		PREC_SINGLE   = 2'b00,
		PREC_RESERVED = 2'b01,
		PREC_DOUBLE   = 2'b10,
		PREC_EXTENDED = 2'b11
	} fcw_prec_e;

	typedef enum logic [1:0] {
		RND_NEAREST = 2'b00,
		RND_DOWN    = 2'b01,
		RND_UP      = 2'b10,
		RND_ZERO    = 2'b11
	} fcw_rnd_e;

	// operation class presented with each rounding request
	typedef enum logic [1:0] {
		OP_PREC_ARITH = 2'b00,
		OP_FULL_ROUND = 2'b01,
		OP_PASS       = 2'b10
	} fcw_op_e;

	typedef struct packed {
		logic                sign;
		logic [EXP_W-1:0]    exp;
		logic [SIG_IN_W-1:0] sig;
		logic                ovf;
	} fcw_round_req_s;

	typedef struct packed {
		logic                 sign;
		logic [EXP_W-1:0]     exp;
		logic [SIG_OUT_W-1:0] sig;
	} fcw_round_rsp_s;

endpackage

// File: verilog/fcw_ctrl.sv
// control word register, exception flags and result rounding
// assumes the sequencer gives one-cycle instruction strobes and normalized
// significands with guard, round and sticky bits appended
// What this block does
// - holds a 16-bit control word, loaded whole, returned by store
// - init or save-state instruction sets the control word to 037F
// - control bits 0..5 keep same-position flags out of the summary bit; the flags still set
// - precision bits 8,9: 00 gives 24, 10 gives 53, 11 gives 64 bits
// - reduced precision rounds and clears significand bits below kept width
// - precision applies only to add, subtract, multiply, divide, square root
// - rounding bits 10,11 choose how unrepresentable results are rounded
// - mode 00 picks the nearest value, ties go to even
// - mode 01 rounds toward minus infinity
// - mode 10 rounds toward plus infinity
// - mode 11 truncates toward zero
// - pick one of the two bracketing values; error below one ulp
// - any rounded-away part sets the inexact flag
// - positive overflow gives +inf when nearest or up, else max finite
// - negative overflow gives -inf when nearest or down, else max finite
// - comparisons, exact and NaN results are not changed by rounding
// - bit 12 is kept and returned but changes nothing
// - summary bit set when any flag is set with its mask clear
// - flags stay set until clear, init, save-state or environment reload
`timescale 1ns/1ps
`default_nettype none

module fcw_ctrl
	import fcw_pkg::*;
(
	// clock and reset
	input  wire logic           clk_sys,
	input  wire logic           rst,
	// control word instructions
	input  wire logic           load_control_instr,
	input  wire logic [15:0]    control_word_in,
	input  wire logic           store_control_instr,
	output logic [15:0]         store_word,
	output logic                store_valid,
	output logic [15:0]         control_word,
	// state instructions
	input  wire logic           fp_init_instr,
	input  wire logic           save_state_instr,
	input  wire logic           clear_exceptions_instr,
	input  wire logic           env_reload_instr,
	input  wire logic [5:0]     env_flags_in,
	// exceptions from the datapath
	input  wire logic [5:0]     exc_detect,
	output logic [5:0]          exc_flags,
	output logic                exception_summary_bit,
	// rounding request
	input  wire logic           req_valid,
	input  wire fcw_op_e        req_op,
	input  wire fcw_round_req_s req,
	// rounding result
	output logic                rsp_valid,
	output fcw_round_rsp_s      rsp,
	output logic                rsp_inexact,
	output logic                rsp_overflow
);

////////////////////////////////////////////////////////////////////////////////

	// shift of last kept bit for a precision code
	function automatic logic [5:0] fcw_kept_shift(input logic [1:0] prec);
		logic [5:0] sh;
		sh = SHIFT_EXT;
		unique case (prec)
			PREC_SINGLE:   sh = SHIFT_SGL;
			PREC_DOUBLE:   sh = SHIFT_DBL;
			PREC_EXTENDED: sh = SHIFT_EXT;
			PREC_RESERVED: sh = SHIFT_EXT;
		endcase
		return sh;
	endfunction

	// bits below the last kept bit
	function automatic logic [SIG_IN_W-1:0] fcw_low_mask(input logic [5:0] sh);
		logic [SIG_IN_W-1:0] one;
		one = {{(SIG_IN_W-1){1'b0}}, 1'b1};
		return (one << sh) - one;
	endfunction

////////////////////////////////////////////////////////////////////////////////

	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [5:0]  flags_reg;
	logic [5:0]  flags_next;
	logic [15:0] store_reg;
	logic        store_vld_reg;

	wire init_cmd = fp_init_instr | save_state_instr;

	// init wins over a same-cycle load; bit 12 stored, never decoded
	assign ctrl_next = init_cmd ? FCW_INIT_VALUE :
		(load_control_instr ? control_word_in : ctrl_reg);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg      <= FCW_INIT_VALUE;
			store_reg     <= 16'h0000;
			store_vld_reg <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			store_vld_reg <= store_control_instr;
			if (store_control_instr) begin
				store_reg <= ctrl_reg;
			end
		end
	end

	assign control_word = ctrl_reg;
	assign store_word   = store_reg;
	assign store_valid  = store_vld_reg;

////////////////////////////////////////////////////////////////////////////////

	wire [5:0]  mask_bits = ctrl_reg[FCW_MASK_MSB:FCW_MASK_LSB];
	wire [1:0]  prec_sel  = ctrl_reg[FCW_PREC_LSB +: 2];
	wire [1:0]  rnd_sel   = ctrl_reg[FCW_RND_LSB +: 2];
	wire        is_pass   = (req_op == OP_PASS);

	// operations outside the precision group always keep 64 bits
	wire [5:0]  kept_sh = (req_op == OP_PREC_ARITH) ?
		fcw_kept_shift(prec_sel) : SHIFT_EXT;

	wire [SIG_IN_W-1:0] low_mask = fcw_low_mask(kept_sh);
	wire [SIG_IN_W-1:0] rem_bits = req.sig & low_mask;
	wire [SIG_IN_W-1:0] half_val = (low_mask >> 1) + 67'h1;
	wire [SIG_IN_W-1:0] unit_val = low_mask + 67'h1;
	wire                lsb_bit  = |(req.sig & unit_val);
	wire                rem_nz   = |rem_bits;
	wire                above_h  = rem_bits > half_val;
	wire                at_half  = rem_bits == half_val;

	logic round_inc;
	always_comb begin
		round_inc = 1'b0;
		unique case (rnd_sel)
			RND_NEAREST:
				round_inc = above_h | (at_half & lsb_bit);
			RND_DOWN:  round_inc = rem_nz & req.sign;
			RND_UP:    round_inc = rem_nz & ~req.sign;
			RND_ZERO:  round_inc = 1'b0;
		endcase
	end

	// bracketing value below plus one unit when rounding away
	wire [SIG_IN_W:0] rnd_sum = {1'b0, req.sig & ~low_mask} +
		(round_inc ? {1'b0, unit_val} : 68'h0);

	wire               sig_carry = rnd_sum[SIG_IN_W];
	wire [SIG_OUT_W-1:0] sig_rnd = sig_carry ?
		rnd_sum[SIG_IN_W:4] : rnd_sum[SIG_IN_W-1:3];
	wire [EXP_W-1:0]   exp_rnd = sig_carry ?
		req.exp + 15'h0001 : req.exp;

	wire ovf_hit = req.ovf | (exp_rnd >= EXP_INF);
	wire to_inf  = (rnd_sel == RND_NEAREST) |
		((rnd_sel == RND_UP) & ~req.sign) |
		((rnd_sel == RND_DOWN) & req.sign);

	wire [SIG_OUT_W-1:0] max_sig = ~low_mask[SIG_IN_W-1:3];
	wire [SIG_OUT_W-1:0] inf_sig = {1'b1, 63'h0};

	fcw_round_rsp_s rsp_next;
	always_comb begin
		rsp_next.sign = req.sign;
		rsp_next.exp  = exp_rnd;
		rsp_next.sig  = sig_rnd;
		if (is_pass) begin
			rsp_next.exp = req.exp;
			rsp_next.sig = req.sig[SIG_IN_W-1:3];
		end else if (ovf_hit) begin
			rsp_next.exp = to_inf ? EXP_INF : EXP_MAX_FIN;
			rsp_next.sig = to_inf ? inf_sig : max_sig;
		end
	end

	wire inexact_now  = req_valid & ~is_pass & (rem_nz | ovf_hit);
	wire overflow_now = req_valid & ~is_pass & ovf_hit;

	fcw_round_rsp_s rsp_reg;
	logic           rsp_vld_reg;
	logic           rsp_inx_reg;
	logic           rsp_ovf_reg;

	// control captured with the request; later writes do not reach it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rsp_reg     <= '0;
			rsp_vld_reg <= 1'b0;
			rsp_inx_reg <= 1'b0;
			rsp_ovf_reg <= 1'b0;
		end else begin
			rsp_vld_reg <= req_valid;
			rsp_inx_reg <= inexact_now;
			rsp_ovf_reg <= overflow_now;
			if (req_valid) begin
				rsp_reg <= rsp_next;
			end
		end
	end

	assign rsp          = rsp_reg;
	assign rsp_valid    = rsp_vld_reg;
	assign rsp_inexact  = rsp_inx_reg;
	assign rsp_overflow = rsp_ovf_reg;

////////////////////////////////////////////////////////////////////////////////

	// flags record every event; masks only stop the exception reaching
	// the summary, so a handler still sees what happened
	wire [5:0] flag_set = exc_detect |
		({5'h00, inexact_now} << FCW_FLAG_INX) |
		({5'h00, overflow_now} << FCW_FLAG_OVF);
	wire       flag_clr = clear_exceptions_instr | init_cmd;

	// a new event in the clearing cycle is kept
	assign flags_next = env_reload_instr ? (env_flags_in | flag_set) :
		(flag_clr ? flag_set : (flags_reg | flag_set));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flags_reg <= 6'h00;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign exc_flags             = flags_reg;
	assign exception_summary_bit = |(flags_reg & ~mask_bits);

////////////////////////////////////////////////////////////////////////////////

	chk_init_value: assert property (@(posedge clk_sys) disable iff (rst)
		init_cmd |=> ctrl_reg == FCW_INIT_VALUE)
		else $error("control word not restored by init");

	chk_load_full: assert property (@(posedge clk_sys) disable iff (rst)
		load_control_instr && !init_cmd |=> ctrl_reg == $past(control_word_in))
		else $error("control word load lost");

	chk_store_data: assert property (@(posedge clk_sys) disable iff (rst)
		store_control_instr |=> store_valid && store_word == $past(ctrl_reg))
		else $error("stored word differs from control word");

	chk_low_zero: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && req_op == OP_PREC_ARITH && !req.ovf &&
		prec_sel == PREC_SINGLE |=> rsp.sig[39:0] == 40'h0)
		else $error("single precision low bits not cleared");

	chk_inexact_set: assert property (@(posedge clk_sys) disable iff (rst)
		inexact_now |=> exc_flags[FCW_FLAG_INX] && rsp_inexact)
		else $error("inexact flag missing");

	chk_ovf_pos: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && req.ovf && !req.sign &&
		rnd_sel == RND_ZERO |=> rsp.exp == EXP_MAX_FIN)
		else $error("positive overflow truncate not max finite");

	chk_ovf_neg: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && req.ovf && req.sign &&
		rnd_sel == RND_DOWN |=> rsp.exp == EXP_INF)
		else $error("negative overflow down not infinity");

	chk_pass_exact: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && is_pass |=> !rsp_inexact &&
		rsp.sig == $past(req.sig[SIG_IN_W-1:3]))
		else $error("pass operation altered");

	chk_summary_mask: assert property (@(posedge clk_sys) disable iff (rst)
		(exc_detect & ~control_word[5:0]) != 6'h00 && !load_control_instr &&
		!init_cmd |=> exception_summary_bit)
		else $error("unmasked event did not raise summary");

	chk_flags_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		exc_flags[0] && !flag_clr && !env_reload_instr |=> exc_flags[0])
		else $error("exception flag dropped without clear");

	chk_round_up: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && !ovf_hit && rnd_sel == RND_UP &&
		!req.sign && rem_nz && !sig_carry |=>
		rsp.sig == $past(sig_rnd) && rsp.sig != $past(req.sig[66:3]))
		else $error("round up did not step the significand");

	chk_dbl_low: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && req_op == OP_PREC_ARITH && !req.ovf &&
		prec_sel == PREC_DOUBLE |=> rsp.sig[10:0] == 11'h000)
		else $error("double precision low bits not cleared");

	chk_rsv_ext: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && req_op == OP_PREC_ARITH && !ovf_hit &&
		prec_sel == PREC_RESERVED && rnd_sel == RND_ZERO |=>
		rsp.sig == $past(req.sig[SIG_IN_W-1:3]))
		else $error("reserved precision did not keep 64 bits");

	chk_full_64: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && req_op == OP_FULL_ROUND && !ovf_hit &&
		rnd_sel == RND_ZERO |=> rsp.sig == $past(req.sig[SIG_IN_W-1:3]))
		else $error("precision field reached a non-arithmetic op");

	chk_trunc_mag: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && !ovf_hit && rnd_sel == RND_ZERO |=>
		rsp.sig <= $past(req.sig[SIG_IN_W-1:3]) && rsp.exp == $past(req.exp))
		else $error("truncation grew the magnitude");

	chk_down_neg: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && !ovf_hit && rnd_sel == RND_DOWN &&
		req.sign && rem_nz && !sig_carry |=>
		rsp.sig > $past(req.sig[SIG_IN_W-1:3]))
		else $error("round down did not grow a negative magnitude");

	chk_down_pos: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && !ovf_hit && rnd_sel == RND_DOWN &&
		!req.sign |=> rsp.sig <= $past(req.sig[SIG_IN_W-1:3]))
		else $error("round down grew a positive value");

	chk_tie_even: assert property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && !ovf_hit && rnd_sel == RND_NEAREST &&
		at_half |=> (rsp.sig & $past(unit_val[SIG_IN_W-1:3])) == 64'h0)
		else $error("tie not rounded to even");

	chk_rsp_time: assert property (@(posedge clk_sys) disable iff (rst)
		rsp_valid == $past(req_valid))
		else $error("response not one cycle after request");

	chk_st_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		store_valid == $past(store_control_instr))
		else $error("store pulse misplaced");

	chk_flag_clr: assert property (@(posedge clk_sys) disable iff (rst)
		clear_exceptions_instr && !env_reload_instr && exc_detect == 6'h00 &&
		!inexact_now && !overflow_now |=> exc_flags == 6'h00)
		else $error("flags not cleared");

	chk_mask_off: assert property (@(posedge clk_sys) disable iff (rst)
		!exception_summary_bit && !load_control_instr && !env_reload_instr &&
		(exc_detect & ~control_word[5:0]) == 6'h00 && !inexact_now &&
		!overflow_now |=> !exception_summary_bit)
		else $error("masked event raised the summary");

	chk_ovf_flag: assert property (@(posedge clk_sys) disable iff (rst)
		overflow_now |=> exc_flags[FCW_FLAG_OVF] && rsp_overflow)
		else $error("overflow flag missing");

	cov_init:   cover property (@(posedge clk_sys) disable iff (rst)
		load_control_instr ##2 fp_init_instr);
	cov_single: cover property (@(posedge clk_sys) disable iff (rst)
		req_valid && req_op == OP_PREC_ARITH && prec_sel == PREC_SINGLE);
	cov_ovf:    cover property (@(posedge clk_sys) disable iff (rst)
		rsp_overflow);
	cov_tie:    cover property (@(posedge clk_sys) disable iff (rst)
		req_valid && !is_pass && at_half);

endmodule

`default_nettype wire

// File: tb/fcw_dp_model.sv
// datapath and sequencer model on the far side of the rounding port
// assumes the bench calls its tasks; drives just after the rising edge
`timescale 1ns/1ps
`default_nettype none

module fcw_dp_model
	import fcw_pkg::*;
(
	// clock
	input  wire logic     clk_sys,
	// rounding request
	output logic          req_valid,
	output fcw_op_e       req_op,
	output fcw_round_req_s req,
	// exception events
	output logic [5:0]    exc_detect
);

	initial begin
		req_valid  = 1'b0;
		req_op     = OP_PASS;
		req        = '0;
		exc_detect = 6'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// one request per call; payload inverted after it so nothing stale
	task automatic issue(input fcw_op_e op, input logic sg,
		input logic [66:0] v, input logic ov);
		@(posedge clk_sys);
		#1;
		req_valid = 1'b1;
		req_op    = op;
		req       = '{sign: sg, exp: 15'h3FFF, sig: v, ovf: ov};
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		req       = ~req;
	endtask

	task automatic raise(input logic [5:0] f);
		@(posedge clk_sys);
		#1;
		exc_detect = f;
		@(posedge clk_sys);
		#1;
		exc_detect = 6'h00;
	endtask

endmodule
`default_nettype wire

// File: tb/fcw_ctrl_tb_top.sv
// self-checking bench for the control word and rounding block
// assumes fcw_ctrl and the datapath model; one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module fcw_ctrl_tb_top;
	import fcw_pkg::*;

	logic           clk_sys = 1'b0;
	logic           rst = 1'b1;
	logic [5:0]     strb = 6'h00;
	logic [15:0]    din = 16'h0000;
	logic [15:0]    store_word, control_word;
	logic           store_valid, exception_summary_bit;
	logic [5:0]     exc_flags, exc_detect;
	logic           req_valid, rsp_valid, rsp_inexact, rsp_overflow;
	fcw_op_e        req_op;
	fcw_round_req_s req;
	fcw_round_rsp_s rsp;
	int             miscompares = 0;
	int             samples_checked = 0;
	int             cycles = 0;

	always #2.5 clk_sys = ~clk_sys;

	fcw_ctrl fcw_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
		.load_control_instr(strb[0]), .control_word_in(din),
		.store_control_instr(strb[1]), .store_word(store_word),
		.store_valid(store_valid), .control_word(control_word),
		.fp_init_instr(strb[2]), .save_state_instr(strb[3]),
		.clear_exceptions_instr(strb[4]), .env_reload_instr(strb[5]),
		.env_flags_in(din[5:0]), .exc_detect(exc_detect),
		.exc_flags(exc_flags),
		.exception_summary_bit(exception_summary_bit),
		.req_valid(req_valid), .req_op(req_op), .req(req),
		.rsp_valid(rsp_valid), .rsp(rsp), .rsp_inexact(rsp_inexact),
		.rsp_overflow(rsp_overflow));

	fcw_dp_model fcw_dp_model_inst (.clk_sys(clk_sys),
		.req_valid(req_valid), .req_op(req_op), .req(req),
		.exc_detect(exc_detect));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("compared %0d, wrong %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// run is about 530 cycles; a hang costs at most about eleven times that
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			give_verdict;
		end
	end

	task automatic check(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// bit k: load, store, init, save, clear, reload
	task automatic strobe(input int k, input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		din  = d;
		strb = 6'(1 << k);
		@(posedge clk_sys);
		#1;
		strb = 6'h00;
	endtask

	// own reference rounding of a 67-bit significand to w kept bits
	function automatic logic [63:0] exp_sig(logic [66:0] v, logic sg,
		logic [1:0] m, int w);
		logic [66:0] k;
		logic        g, st, inc;
		k   = v >> (67 - w);
		g   = v[66 - w];
		st  = |(v & ((67'h1 << (66 - w)) - 67'h1));
		inc = (m == 2'b00) ? (g & (st | k[0])) :
			(m == 2'b01) ? (sg & (g | st)) :
			(m == 2'b10) ? (~sg & (g | st)) : 1'b0;
		return 64'((k + 67'(inc)) << (64 - w));
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_load_store;
		check("cw_reset", 64'(control_word), 64'h037F);
		strobe(0, 16'hFA5A);
		check("cw_load", 64'(control_word), 64'hFA5A);
		strobe(1, 16'h0000);
		check("st_valid", 64'(store_valid), 64'h1);
		check("st_word", 64'(store_word), 64'hFA5A);
		strobe(3, 16'h0000);
		check("cw_save", 64'(control_word), 64'h037F);
		strobe(0, 16'h1234);
		strobe(2, 16'h0000);
		check("cw_init", 64'(control_word), 64'h037F);
	endtask

	task automatic t_round;
		logic [66:0] v [3];
		int          w;
		logic [1:0]  m, p;
		v = '{67'h6_AAAA_AAAA_AAAA_AAAC, 67'h5_0000_0100_0000_2000,
			67'h4_0000_0000_0000_0000};
		for (int pi = 0; pi < 4; pi++) begin
			for (int mi = 0; mi < 4; mi++) begin
				p = 2'(pi);
				m = 2'(mi);
				strobe(0, {4'h0, m, p, 8'h7F});
				for (int x = 0; x < 12; x++) begin
					w = x[0] ? 64 : (p == 2'b00) ? 24 : (p == 2'b10) ? 53 : 64;
					fcw_dp_model_inst.issue(x[0] ? OP_FULL_ROUND :
						OP_PREC_ARITH, x[1], v[x/4], 1'b0);
					check("rsp_valid", 64'(rsp_valid), 64'h1);
					check("rsp_sig", rsp.sig,
						exp_sig(v[x/4], x[1], m, w));
					check("rsp_exp", 64'({rsp.sign, rsp.exp}),
						64'({x[1], 15'h3FFF}));
					check("rsp_inx", 64'(rsp_inexact),
						64'(|(v[x/4] << w)));
				end
			end
		end
		// compare class keeps the full significand even in directed mode
		strobe(0, 16'h087F);
		fcw_dp_model_inst.issue(OP_PASS, 1'b0, v[0], 1'b0);
		check("pass_sig", rsp.sig, v[0][66:3]);
		check("pass_inx", 64'(rsp_inexact), 64'h0);
	endtask

	task automatic t_overflow;
		logic       inf;
		logic [1:0] md;
		for (int x = 0; x < 16; x++) begin
			md = 2'(x / 2);
			strobe(0, {4'h0, md, x[3] ? 2'b00 : 2'b11, 8'h7F});
			fcw_dp_model_inst.issue(OP_PREC_ARITH, x[0],
				67'h4_0000_0000_0000_0000, 1'b1);
			inf = (md == 2'b00) || (md == 2'b10 && !x[0]) ||
				(md == 2'b01 && x[0]);
			check("ovf_sig", rsp.sig, inf ? 64'h8000_0000_0000_0000 :
				x[3] ? 64'hFFFF_FF00_0000_0000 :
				64'hFFFF_FFFF_FFFF_FFFF);
			check("ovf_exp", 64'({rsp.sign, rsp.exp}),
				64'({x[0], inf ? 15'h7FFF : 15'h7FFE}));
			check("ovf_out", 64'(rsp_overflow), 64'h1);
		end
	endtask

	task automatic t_flags;
		strobe(2, 16'h0000);
		fcw_dp_model_inst.raise(6'h04);
		check("flag_set", 64'(exc_flags), 64'h04);
		check("sum_mask", 64'(exception_summary_bit), 64'h0);
		strobe(0, 16'h037B);
		check("sum_unmask", 64'(exception_summary_bit), 64'h1);
		repeat (5) @(posedge clk_sys);
		check("flag_hold", 64'(exc_flags), 64'h04);
		strobe(4, 16'h0000);
		check("flag_clr", 64'(exc_flags), 64'h00);
		check("sum_clr", 64'(exception_summary_bit), 64'h0);
		fcw_dp_model_inst.raise(6'h04);
		check("sum_event", 64'(exception_summary_bit), 64'h1);
		strobe(5, 16'h0015);
		check("flag_env", 64'(exc_flags), 64'h15);
		strobe(3, 16'h0000);
		check("flag_save", 64'(exc_flags), 64'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_load_store;
		t_round;
		t_overflow;
		t_flags;
		give_verdict;
	end

endmodule
`default_nettype wire
